// >>> pfc_pkg.sv
// constants for the light_profiler feature configuration register
// Functional notes
// - writes setting unsupported bits raise protection_fault
// - bits 31:1 mirrored to user feature leaf
// - core tag copied into record core field
// - bits 47:40 give threshold interrupt vector
// - reset clears whole register to zero
// - bit 1 allows program sample instruction
// - bit 2 allows retired instruction counting
// - bit 3 allows retired branch counting
// - bit 4 allows cache miss counting
// - bit 5 allows active cycle counting
// - bit 6 allows reference cycle counting
// - bit 29 allows free running sampling
// - bit 30 stores timestamp when counter exists
// - bit 31 allows threshold interrupt
// - bits 0, 28:7, 63:48 are reserved
// - supported mask uses same bit positions
`default_nettype none
package pfc_pkg;
  // ==========================================================
  // register map
  localparam logic [31:0] PFC_CFG_ADDR    = 32'hc0000105;
  localparam logic [63:0] PFC_CFG_RESET   = 64'h0;
  localparam logic [63:0] PFC_CFG_WMASK   = 64'h0000_ffff_e000_007e;
  localparam int          PFC_BIT_SAMPLE  = 1;
  localparam int          PFC_BIT_INSN    = 2;
  localparam int          PFC_BIT_BRANCH  = 3;
  localparam int          PFC_BIT_MISS    = 4;
  localparam int          PFC_BIT_ACTIVE  = 5;
  localparam int          PFC_BIT_REF     = 6;
  localparam int          PFC_BIT_FREE    = 29;
  localparam int          PFC_BIT_TSTAMP  = 30;
  localparam int          PFC_BIT_THRINT  = 31;
  localparam int          PFC_TAG_LSB     = 32;
  localparam int          PFC_VEC_LSB     = 40;
endpackage : pfc_pkg
`default_nettype wire

// >>> pfc_cfg_if.sv
// interface carrying the decoded configuration between modules
`timescale 1ns/1ps
`default_nettype none
interface pfc_cfg_if;
  logic [63:0] cfg;
  logic [6:1]  ev_allow;
  logic        free_run;
  logic        tstamp;
  logic        thr_int;
  logic [7:0]  core_tag;
  logic [7:0]  vector;
  modport src (output cfg);
  modport dec (input cfg, output ev_allow, free_run, tstamp, thr_int, core_tag, vector);
  modport use_side (input ev_allow, free_run, tstamp, thr_int, core_tag, vector);
endinterface : pfc_cfg_if
`default_nettype wire

// >>> pfc_decode.sv
// field decoder for the configuration register
`timescale 1ns/1ps
`default_nettype none
module pfc_decode (
  pfc_cfg_if.dec c  // configuration fields
);
  import pfc_pkg::*;
  genvar g;
  // ==========================================================
  // per-event allow bits
  generate
    for (g = PFC_BIT_SAMPLE; g <= PFC_BIT_REF; g++) begin : g_ev
      assign c.ev_allow[g] = c.cfg[g];
    end
  endgenerate
  assign c.free_run = c.cfg[PFC_BIT_FREE];
  assign c.tstamp   = c.cfg[PFC_BIT_TSTAMP];
  assign c.thr_int  = c.cfg[PFC_BIT_THRINT];
  assign c.core_tag = c.cfg[PFC_TAG_LSB +: 8];
  assign c.vector   = c.cfg[PFC_VEC_LSB +: 8];
endmodule : pfc_decode
`default_nettype wire

// >>> pfc_config.sv
// light_profiler feature configuration register with write check and gating
`timescale 1ns/1ps
`default_nettype none
module pfc_config (
  input  wire logic        clk_i,             // core clock
  input  wire logic        resetn_i,          // async reset, active low
  input  wire logic        msr_wr_i,          // register write strobe
  input  wire logic        msr_rd_i,          // register read strobe
  input  wire logic [31:0] msr_addr_i,        // register number
  input  wire logic [63:0] msr_wdata_i,       // write data
  output logic      [63:0] msr_rdata_o,       // read data
  output logic             msr_hit_o,         // address decodes to this register
  output logic             protection_fault_o,// write refused, one-cycle pulse
  input  wire logic [31:0] feature_supported_i,// supported feature mask
  output logic      [31:0] feature_leaf_o,    // user visible copy of bits 31:1
  input  wire logic [6:1]  event_req_i,       // event counting requests per id
  output logic      [6:1]  event_ok_o,        // event permitted
  input  wire logic        sample_insn_i,     // program sample instruction issued
  output logic             sample_insn_ok_o,  // sample instruction allowed
  output logic             free_running_o,    // continuous sampling mode in force
  input  wire logic        record_wr_i,       // event record being written
  input  wire logic        tstamp_present_i,  // timestamp counter exists
  input  wire logic [63:0] tstamp_i,          // timestamp counter value
  output logic      [7:0]  record_core_field_o,// core field of record
  output logic      [63:0] record_tstamp_o,   // timestamp field of record
  input  wire logic        threshold_hit_i,   // ring buffer threshold exceeded
  output logic             thr_irq_o,         // threshold interrupt request
  output logic      [7:0]  thr_vector_o       // vector of interrupt
);
  import pfc_pkg::*;
  // ==========================================================
  // register
  logic [63:0] cfg;
  logic [63:0] next_cfg;
  logic        fault;
  logic        next_fault;
  logic [63:0] rdata;
  logic [63:0] next_rdata;
  logic        hit;
  logic [63:0] allowed;
  pfc_cfg_if   cif ();
  assign hit = (msr_addr_i == PFC_CFG_ADDR);
  // supported flags share the config bit positions
  assign allowed = PFC_CFG_WMASK & {32'hffffffff, feature_supported_i};
  always_comb begin
    next_cfg   = cfg;
    next_fault = 1'b0;
    next_rdata = rdata;
    if (msr_wr_i && hit) begin
      if ((msr_wdata_i[31:0] & ~allowed[31:0] & PFC_CFG_WMASK[31:0]) != 32'h0) begin
        next_fault = 1'b1;
      end else begin
        next_cfg = msr_wdata_i & allowed;
      end
    end
    // a read in the write cycle returns the old value
    if (msr_rd_i && hit) begin
      next_rdata = cfg;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg   <= PFC_CFG_RESET;
      fault <= 1'b0;
      rdata <= 64'h0;
    end else begin
      cfg   <= next_cfg;
      fault <= next_fault;
      rdata <= next_rdata;
    end
  end
  assign cif.cfg = cfg;
  pfc_decode u_dec (
    .c (cif)
  );
  // ==========================================================
  // outputs
  assign msr_rdata_o        = rdata;
  assign msr_hit_o          = hit;
  assign protection_fault_o = fault;
  assign feature_leaf_o     = {cfg[31:1], 1'b0};
  assign event_ok_o         = event_req_i & cif.ev_allow;
  assign sample_insn_ok_o   = sample_insn_i & cif.ev_allow[PFC_BIT_SAMPLE];
  assign free_running_o     = cif.free_run;
  assign thr_vector_o       = cif.vector;

  // ==========================================================
  // event record fields and threshold interrupt
  logic [7:0]  core_q;
  logic [7:0]  next_core_q;
  logic [63:0] ts_q;
  logic [63:0] next_ts_q;
  logic        irq_q;
  logic        next_irq_q;
  logic        ts_store;

  // timestamp only when enabled and the counter exists
  assign ts_store = cif.tstamp & tstamp_present_i;

  always_comb begin
    next_core_q = core_q;
    next_ts_q   = ts_q;
    next_irq_q  = threshold_hit_i & cif.thr_int;
    if (record_wr_i) begin
      next_core_q = cif.core_tag;
      next_ts_q   = ts_store ? tstamp_i : 64'h0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_q <= 8'h0;
      ts_q   <= 64'h0;
      irq_q  <= 1'b0;
    end else begin
      core_q <= next_core_q;
      ts_q   <= next_ts_q;
      irq_q  <= next_irq_q;
    end
  end

  assign record_core_field_o = core_q;
  assign record_tstamp_o     = ts_q;
  assign thr_irq_o           = irq_q;

  // ==========================================================
  // checks: register access

  a_fault_blocks: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (msr_wr_i && msr_hit_o
      && (msr_wdata_i[31:0] & PFC_CFG_WMASK[31:0] & ~feature_supported_i) != 32'h0)
      |=> (protection_fault_o && $stable(cfg)))
    else $error("bad write not refused");

  a_write_takes: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (msr_wr_i && msr_hit_o
      && (msr_wdata_i[31:0] & PFC_CFG_WMASK[31:0] & ~feature_supported_i) == 32'h0)
      |=> (!protection_fault_o && cfg == ($past(msr_wdata_i) & PFC_CFG_WMASK)))
    else $error("good write not stored");

  a_fault_source: assert property (@(posedge clk_i) disable iff (!resetn_i)
    protection_fault_o |-> $past(msr_wr_i && msr_hit_o))
    else $error("fault without write");

  a_cfg_holds: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !(msr_wr_i && msr_hit_o) |=> $stable(cfg))
    else $error("config changed without write");

  a_supported_only: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (msr_wr_i && msr_hit_o)
      |=> (cfg[31:0] & ~$past(feature_supported_i)) == 32'h0 || $stable(cfg))
    else $error("unsupported bit set");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (cfg & ~PFC_CFG_WMASK) == 64'h0)
    else $error("reserved bit set");

  a_read_data: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (msr_rd_i && msr_hit_o) |=> msr_rdata_o == $past(cfg))
    else $error("read data wrong");

  a_read_holds: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !(msr_rd_i && msr_hit_o) |=> $stable(msr_rdata_o))
    else $error("read data moved");

  // ==========================================================
  // checks: decoded fields

  a_leaf_copy: assert property (@(posedge clk_i) disable iff (!resetn_i)
    feature_leaf_o[31:1] == cfg[31:1] && !feature_leaf_o[0])
    else $error("leaf mismatch");

  a_event_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (event_ok_o & ~cfg[6:1]) == 6'h0)
    else $error("event allowed while off");

  a_sample_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sample_insn_ok_o |-> cfg[1])
    else $error("sample allowed while off");

  a_free_run: assert property (@(posedge clk_i) disable iff (!resetn_i)
    free_running_o == cfg[29])
    else $error("mode mismatch");

  a_vector_out: assert property (@(posedge clk_i) disable iff (!resetn_i)
    thr_vector_o == cfg[47:40])
    else $error("vector mismatch");

  // ==========================================================
  // checks: record fields and interrupt

  a_core_tag: assert property (@(posedge clk_i) disable iff (!resetn_i)
    record_wr_i |=> record_core_field_o == $past(cfg[39:32]))
    else $error("core field wrong");

  a_record_holds: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !record_wr_i |=> $stable(record_core_field_o) && $stable(record_tstamp_o))
    else $error("record fields moved");

  a_tstamp_take: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (record_wr_i && cfg[30] && tstamp_present_i) |=> record_tstamp_o == $past(tstamp_i))
    else $error("timestamp not stored");

  a_tstamp_store: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (record_wr_i && !(cfg[30] && tstamp_present_i)) |=> record_tstamp_o == 64'h0)
    else $error("timestamp stored while disabled");

  a_irq_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    thr_irq_o |-> $past(threshold_hit_i && cfg[31]))
    else $error("irq while disabled");

  a_irq_fires: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (threshold_hit_i && cfg[31]) |=> thr_irq_o)
    else $error("irq missing");

  // ==========================================================
  // coverage of main scenarios

  c_fault: cover property (@(posedge clk_i) disable iff (!resetn_i) protection_fault_o);
  c_irq: cover property (@(posedge clk_i) disable iff (!resetn_i) thr_irq_o);
  c_ts: cover property (@(posedge clk_i) disable iff (!resetn_i)
    record_wr_i && cfg[30] && tstamp_present_i);
  c_write_ok: cover property (@(posedge clk_i) disable iff (!resetn_i)
    msr_wr_i && msr_hit_o ##1 !protection_fault_o);
  c_read: cover property (@(posedge clk_i) disable iff (!resetn_i) msr_rd_i && msr_hit_o);
endmodule : pfc_config
`default_nettype wire

// >>> pfc_config_test.sv
// self-checking bench for the profiler feature configuration register
`timescale 1ns/1ps
`default_nettype none
module pfc_config_test;
  import pfc_pkg::*;
  logic        clk, rstn, wr, rd, sx, rw, tp, th, hit, flt, sok, frun, irq;
  logic [31:0] addr, sup, leaf;
  logic [63:0] wd, ts, rdata, rts;
  logic [6:1]  ev, eok;
  logic [7:0]  rcf, vec;
  int          fail_count, check_count;

  pfc_config dut (.clk_i(clk), .resetn_i(rstn), .msr_wr_i(wr), .msr_rd_i(rd),
    .msr_addr_i(addr), .msr_wdata_i(wd), .msr_rdata_o(rdata), .msr_hit_o(hit),
    .protection_fault_o(flt), .feature_supported_i(sup), .feature_leaf_o(leaf),
    .event_req_i(ev), .event_ok_o(eok), .sample_insn_i(sx), .sample_insn_ok_o(sok),
    .free_running_o(frun), .record_wr_i(rw), .tstamp_present_i(tp), .tstamp_i(ts),
    .record_core_field_o(rcf), .record_tstamp_o(rts), .threshold_hit_i(th),
    .thr_irq_o(irq), .thr_vector_o(vec));

  // ==========================================================
  // access tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // idle cycle first, so strobes never toggle twice in one step
  task automatic wr_reg(input logic [31:0] a, input logic [63:0] d, input logic f);
    @(posedge clk);
    #1 addr = a;
    wd = d;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
    chk({63'h0, flt}, {63'h0, f});
  endtask : wr_reg

  task automatic rd_reg(input logic [63:0] exp);
    @(posedge clk);
    #1 addr = PFC_CFG_ADDR;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    chk(rdata, exp);
  endtask : rd_reg

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // clock and sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    {rstn, wr, rd, sx, rw, tp, th} = '0;
    addr = PFC_CFG_ADDR;
    sup = '1;
    wd = '0;
    ts = 64'h0123_4567_89ab_cdef;
    ev = '1;
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    rd_reg(64'h0);
    chk({58'h0, eok}, 64'h0);
    wr_reg(PFC_CFG_ADDR, 64'hffff_5aa5_e000_007f, 1'b0);
    rd_reg(64'h0000_5aa5_e000_007e);
    chk({32'h0, leaf}, 64'he000_007e);
    chk({56'h0, vec}, 64'h5a);
    chk({63'h0, frun}, 64'h1);
    tp = 1'b1;
    rw = 1'b1;
    th = 1'b1;
    @(posedge clk);
    #1 rw = 1'b0;
    th = 1'b0;
    chk({56'h0, rcf}, 64'ha5);
    chk(rts, ts);
    chk({63'h0, irq}, 64'h1);
    @(posedge clk);
    #1 tp = 1'b0;
    rw = 1'b1;
    @(posedge clk);
    #1 rw = 1'b0;
    chk(rts, 64'h0);
    tp = 1'b1;
    wr_reg(PFC_CFG_ADDR + 32'h1, 64'h0, 1'b0);
    chk({63'h0, hit}, 64'h0);
    sup = 32'h7fff_fffb;
    wr_reg(PFC_CFG_ADDR, 64'h4, 1'b1);
    wr_reg(PFC_CFG_ADDR, 64'h8000_0000, 1'b1);
    rd_reg(64'h0000_5aa5_e000_007e);
    wr_reg(PFC_CFG_ADDR, 64'h82, 1'b0);
    rd_reg(64'h2);
    sup = '1;
    sx = 1'b1;
    foreach (ev[i]) begin
      wr_reg(PFC_CFG_ADDR, 64'h1 << i, 1'b0);
      chk({58'h0, eok}, {58'h0, 6'h1 << (i - 1)});
      chk({63'h0, sok}, {63'h0, i == 1});
    end
    chk({63'h0, frun}, 64'h0);
    rw = 1'b1;
    th = 1'b1;
    @(posedge clk);
    #1 rw = 1'b0;
    th = 1'b0;
    chk(rts, 64'h0);
    chk({63'h0, irq}, 64'h0);
    @(posedge clk);
    #1 rstn = 1'b0;
    @(posedge clk);
    #1 rstn = 1'b1;
    chk({32'h0, leaf}, 64'h0);
    rd_reg(64'h0);
    tally_and_finish();
  end
endmodule : pfc_config_test
`default_nettype wire
